// [dsw_assertions.sv]
/*
 Checker on the status word encoder ports, bound after the module.
 Assumes one clk_sys domain and a synchronous active-low resetn.
*/
`timescale 1ns/100ps
module dsw_chk
#(
   parameter int EVT_W = 8,
   parameter int REACT_CYC = 5000
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // state machine and events
   input wire logic [2:0] drive_state,
   input wire logic [2:0] op_mode,
   input wire logic homing_active,
   input wire logic motor_powered,
   input wire logic service_owns_access,
   input wire logic home_reached,
   input wire logic at_target,
   input wire logic homing_done,
   input wire logic [EVT_W-1:0] warn_events,
   input wire logic [EVT_W-1:0] vend_events,
   input wire logic [EVT_W-1:0] ilim_events,
   input wire logic [EVT_W-1:0] warn_select,
   input wire logic [EVT_W-1:0] vend_select,
   input wire logic [EVT_W-1:0] ilim_select,
   // outputs
   input wire logic [15:0] drive_state_report,
   input wire logic fault_react_done
);
   localparam logic [6:0] ST [8] = '{7'h00, 7'h40, 7'h21, 7'h23,
      7'h27, 7'h07, 7'h0f, 7'h08};
   logic [5:0] st_w;
   logic [2:0] ev3;
   logic tgt_w;
   logic [16:0] cnt_q;
   assign st_w = {ST[drive_state][6:5], ST[drive_state][3:0]};
   assign ev3 = {|(ilim_events & ilim_select),
      |(vend_events & vend_select), |(warn_events & warn_select)};
   assign tgt_w = (op_mode == 3'h6 || (op_mode == 3'h7 && homing_active))
      ? home_reached : at_target;
   // saturates so a stuck state never wraps back under the window
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || drive_state != 3'h6)
         cnt_q <= 17'h0;
      else if (cnt_q != 17'h1ffff)
         cnt_q <= cnt_q + 17'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // raw events and selects still, so no pipelined mix can show
   sequence s_evt_still;
      resetn && $stable({warn_events, vend_events, ilim_events})
         && $stable({warn_select, vend_select, ilim_select});
   endsequence
   property p_state;
      $past(resetn, 2) |-> {drive_state_report[6:5],
         drive_state_report[3:0]} == $past(st_w);
   endproperty
   property p_volt;
      $past(resetn, 2) |-> drive_state_report[4] == $past(motor_powered);
   endproperty
   property p_remote;
      $past(resetn, 2) |->
         drive_state_report[9] != $past(service_owns_access);
   endproperty
   property p_target;
      $past(resetn, 2) |-> drive_state_report[10] == $past(tgt_w);
   endproperty
   property p_homed;
      $past(resetn, 2) |-> drive_state_report[12] == $past(homing_done);
   endproperty
   property p_evt;
      s_evt_still[*7] |-> {drive_state_report[11],
         drive_state_report[8], drive_state_report[7]} == ev3;
   endproperty
   property p_spare;
      drive_state_report[15:13] == 3'h0;
   endproperty
   property p_react_win;
      $rose(fault_react_done) |->
         cnt_q >= REACT_CYC - 1 && cnt_q <= REACT_CYC + 3;
   endproperty
   property p_react_due;
      drive_state == 3'h6 && cnt_q == REACT_CYC + 3 |=> fault_react_done;
   endproperty
   property p_react_clr;
      drive_state != 3'h6 |=> !fault_react_done;
   endproperty
   a_state: assert property (p_state)
      else $error("state bits differ from state code");
   a_volt: assert property (p_volt)
      else $error("voltage bit wrong");
   a_remote: assert property (p_remote)
      else $error("remote bit wrong");
   a_target: assert property (p_target)
      else $error("target bit wrong");
   a_homed: assert property (p_homed)
      else $error("homing complete bit wrong");
   a_evt: assert property (p_evt)
      else $error("event bits wrong");
   a_spare: assert property (p_spare)
      else $error("spare bits not zero");
   a_react_win: assert property (p_react_win)
      else $error("reaction done rose off time");
   a_react_due: assert property (p_react_due)
      else $error("reaction done late");
   a_react_clr: assert property (p_react_clr)
      else $error("reaction done outside state");
endmodule : dsw_chk

bind dsw_drive_status_word_encoder dsw_chk #(.EVT_W(EVT_W),
   .REACT_CYC(REACT_CYC)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
   .drive_state(drive_state), .op_mode(op_mode),
   .homing_active(homing_active), .motor_powered(motor_powered),
   .service_owns_access(service_owns_access),
   .home_reached(home_reached), .at_target(at_target),
   .homing_done(homing_done), .warn_events(warn_events),
   .vend_events(vend_events), .ilim_events(ilim_events),
   .warn_select(warn_select), .vend_select(vend_select),
   .ilim_select(ilim_select), .drive_state_report(drive_state_report),
   .fault_react_done(fault_react_done));

// [dsw_consts.svh]
/*
 Constants for the drive status word encoder: bit positions, state codes,
 encodings and timing counts.
 Assumes a 50 MHz system clock; included by the design module.
*/
// Contract
// - State encoded in bits 0-3, 5 and 6, uniquely identifiable.
// - Not state_prepared_flag: bits 6,3,2,1,0 low.
// - Switch on disabled: bit 6 high, bits 3..0 low.
// - Prepared to switch on: bit6 low, bit5 high, bits 3..0 = 0001.
// - Switched on: bit6 low, bit5 high, bits 3..0 = 0011.
// - Operation enabled: bit6 low, bit5 high, bits 3..0 = 0111.
// - Fault reaction active: bit6 low, bits 3..0 = 1111.
// - Fault: bit6 low, bits 3..0 = 1000.
// - Quick stop active: bits 6,5 low, bits 3..0 = 0111.
// - Bit 4 high exactly while motor power applied.
// - Bit 9 low while service channel holds access, else high.
// - Homing mode: bit 10 set once home reached.
// - Custom mode with homing active: bit 10 set on home reached.
// - Other modes: bit 10 set when actual value at target.
// - Bit 12 high once homing completed, otherwise low.
// - Bits 7, 8, 11 from events chosen by programmable selects.
// - Fault reaction exits to fault on its own, 100 us to 2 ms.
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH

`define DSW_BIT_STATE_PREPARED_FLAG 0
`define DSW_BIT_SWON 1
`define DSW_BIT_OPEN 2
`define DSW_BIT_FAULT 3
`define DSW_BIT_VOLT 4
`define DSW_BIT_QSTOP 5
`define DSW_BIT_SWDIS 6
`define DSW_BIT_WARN 7
`define DSW_BIT_VEND 8
`define DSW_BIT_REMOTE 9
`define DSW_BIT_TARGET 10
`define DSW_BIT_ILIM 11
`define DSW_BIT_HOMED 12

`define DSW_RESET_WORD 16'h0000

// state codes on drive_state
`define DSW_ST_NOT_READY 3'h0
`define DSW_ST_SW_DISABLED 3'h1
`define DSW_ST_READY 3'h2
`define DSW_ST_SWITCHED_ON 3'h3
`define DSW_ST_OP_ENABLED 3'h4
`define DSW_ST_QUICK_STOP 3'h5
`define DSW_ST_FAULT_REACT 3'h6
`define DSW_ST_FAULT 3'h7

// operating mode codes on op_mode
`define DSW_MODE_HOMING 3'h6
`define DSW_MODE_CUSTOM 3'h7

// fault reaction dwell window
`define DSW_CLK_HZ 50000000
`define DSW_REACT_MIN_US 100
`define DSW_REACT_MAX_US 2000
`define DSW_REACT_MIN_CYC ((`DSW_REACT_MIN_US * (`DSW_CLK_HZ / 1000000)))
`define DSW_REACT_MAX_CYC ((`DSW_REACT_MAX_US * (`DSW_CLK_HZ / 1000000)))

`endif

// [dsw_drive_status_word_encoder.sv]
/*
 Drive status word encoder: samples the control state machine and drive
 events each clock and registers the 16-bit read-only status word. Also
 times the fault reaction dwell and requests the exit to fault.
 Assumes drive_state, op_mode and the event inputs come from logic on
 clk_sys; the three programmable event buses are synchronised here since
 they may come from asynchronous drive monitors.
*/
`timescale 1ns/100ps
`include "dsw_consts.svh"

module dsw_drive_status_word_encoder
   import dsw_pkg::*;
#(
   parameter int EVT_W = 8,
   parameter int REACT_CYC = `DSW_REACT_MIN_CYC
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // control state machine
   input wire logic [2:0] drive_state,
   input wire logic [2:0] op_mode,
   input wire logic homing_active,
   // drive events
   input wire logic motor_powered,
   input wire logic service_owns_access,
   input wire logic home_reached,
   input wire logic at_target,
   input wire logic homing_done,
   input wire logic [EVT_W-1:0] warn_events,
   input wire logic [EVT_W-1:0] vend_events,
   input wire logic [EVT_W-1:0] ilim_events,
   // programmable status source selects
   input wire logic [EVT_W-1:0] warn_select,
   input wire logic [EVT_W-1:0] vend_select,
   input wire logic [EVT_W-1:0] ilim_select,
   // outputs
   output logic [15:0] drive_state_report,
   output logic fault_react_done
);

   // whole register set; the event pipeline width follows EVT_W
   typedef struct packed
   {
      dsw_state_t core;
      logic [EVT_W-1:0] warn_s1;
      logic [EVT_W-1:0] warn_s2;
      logic [EVT_W-1:0] warn_s3;
      logic [EVT_W-1:0] warn_held;
      logic [EVT_W-1:0] vend_s1;
      logic [EVT_W-1:0] vend_s2;
      logic [EVT_W-1:0] vend_s3;
      logic [EVT_W-1:0] vend_held;
      logic [EVT_W-1:0] ilim_s1;
      logic [EVT_W-1:0] ilim_s2;
      logic [EVT_W-1:0] ilim_s3;
      logic [EVT_W-1:0] ilim_held;
   } dsw_regs_t;

   dsw_regs_t r_q;
   dsw_regs_t r_d;

   // any selected event raises the bit
   function automatic logic sel_hit(input logic [EVT_W-1:0] ev,
                                    input logic [EVT_W-1:0] sel);
      sel_hit = |(ev & sel);
   endfunction : sel_hit

   // per bit: stage three counts only once stages two and three agree
   function automatic logic [EVT_W-1:0] agreed(
      input logic [EVT_W-1:0] s2,
      input logic [EVT_W-1:0] s3,
      input logic [EVT_W-1:0] old);
      logic [EVT_W-1:0] same;
      same = ~(s2 ^ s3);
      agreed = (same & s3) | (~same & old);
   endfunction : agreed

   // bits 6..0 for one state code, bit 4 left to the caller; the
   // don't-care bits read zero so each state shows one fixed pattern
   function automatic logic [6:0] state_bits(input logic [2:0] st);
      logic [6:0] b;
      b = 7'h00;
      case (st)
         `DSW_ST_NOT_READY:
         begin
            b = 7'h00;
         end
         `DSW_ST_SW_DISABLED:
         begin
            b[`DSW_BIT_SWDIS] = 1'b1;
         end
         `DSW_ST_READY:
         begin
            b[`DSW_BIT_QSTOP] = 1'b1;
            b[`DSW_BIT_STATE_PREPARED_FLAG] = 1'b1;
         end
         `DSW_ST_SWITCHED_ON:
         begin
            b[`DSW_BIT_QSTOP] = 1'b1;
            b[`DSW_BIT_SWON] = 1'b1;
            b[`DSW_BIT_STATE_PREPARED_FLAG] = 1'b1;
         end
         `DSW_ST_OP_ENABLED:
         begin
            b[`DSW_BIT_QSTOP] = 1'b1;
            b[`DSW_BIT_OPEN] = 1'b1;
            b[`DSW_BIT_SWON] = 1'b1;
            b[`DSW_BIT_STATE_PREPARED_FLAG] = 1'b1;
         end
         `DSW_ST_QUICK_STOP:
         begin
            b[`DSW_BIT_OPEN] = 1'b1;
            b[`DSW_BIT_SWON] = 1'b1;
            b[`DSW_BIT_STATE_PREPARED_FLAG] = 1'b1;
         end
         `DSW_ST_FAULT_REACT:
         begin
            b[`DSW_BIT_FAULT] = 1'b1;
            b[`DSW_BIT_OPEN] = 1'b1;
            b[`DSW_BIT_SWON] = 1'b1;
            b[`DSW_BIT_STATE_PREPARED_FLAG] = 1'b1;
         end
         `DSW_ST_FAULT:
         begin
            b[`DSW_BIT_FAULT] = 1'b1;
         end
         default:
         begin
            b = 7'h00;
         end
      endcase
      state_bits = b;
   endfunction : state_bits

   // homing and custom-with-homing report home, all others the target
   function automatic logic target_bit(input logic [2:0] mode,
                                       input logic homing,
                                       input logic home,
                                       input logic arrived);
      logic t;
      if (mode == `DSW_MODE_HOMING)
      begin
         t = home;
      end
      else if (mode == `DSW_MODE_CUSTOM && homing)
      begin
         t = home;
      end
      else
      begin
         t = arrived;
      end
      target_bit = t;
   endfunction : target_bit

   always_comb
   begin
      logic [15:0] w;
      logic [6:0] sb;
      logic [EVT_W-1:0] warn_ok;
      logic [EVT_W-1:0] vend_ok;
      logic [EVT_W-1:0] ilim_ok;
      w = `DSW_RESET_WORD;
      sb = 7'h00;
      warn_ok = agreed(r_q.warn_s2, r_q.warn_s3, r_q.warn_held);
      vend_ok = agreed(r_q.vend_s2, r_q.vend_s3, r_q.vend_held);
      ilim_ok = agreed(r_q.ilim_s2, r_q.ilim_s3, r_q.ilim_held);
      r_d = r_q;
      // stage one feeds stage two only, so no half-settled bit escapes
      r_d.warn_s1 = warn_events;
      r_d.warn_s2 = r_q.warn_s1;
      r_d.warn_s3 = r_q.warn_s2;
      r_d.vend_s1 = vend_events;
      r_d.vend_s2 = r_q.vend_s1;
      r_d.vend_s3 = r_q.vend_s2;
      r_d.ilim_s1 = ilim_events;
      r_d.ilim_s2 = r_q.ilim_s1;
      r_d.ilim_s3 = r_q.ilim_s2;
      r_d.warn_held = warn_ok;
      r_d.vend_held = vend_ok;
      r_d.ilim_held = ilim_ok;
      sb = state_bits(drive_state);
      w[6:5] = sb[6:5];
      w[3:0] = sb[3:0];
      w[`DSW_BIT_VOLT] = motor_powered;
      w[`DSW_BIT_REMOTE] = !service_owns_access;
      w[`DSW_BIT_TARGET] = target_bit(op_mode, homing_active,
                                      home_reached, at_target);
      w[`DSW_BIT_HOMED] = homing_done;
      w[`DSW_BIT_WARN] = sel_hit(warn_ok, warn_select);
      w[`DSW_BIT_VEND] = sel_hit(vend_ok, vend_select);
      w[`DSW_BIT_ILIM] = sel_hit(ilim_ok, ilim_select);
      w[15:13] = 3'h0;
      r_d.core.word = w;
      // fault reaction dwell, restarts on every entry
      r_d.core.react_done = 1'b0;
      case (r_q.core.react)
         DSW_RX_IDLE:
         begin
            r_d.core.react_cnt = '0;
            if (drive_state == `DSW_ST_FAULT_REACT)
            begin
               r_d.core.react = DSW_RX_WAIT;
            end
         end
         DSW_RX_WAIT:
         begin
            if (drive_state != `DSW_ST_FAULT_REACT)
            begin
               r_d.core.react = DSW_RX_IDLE;
            end
            else if (r_q.core.react_cnt >= 17'(REACT_CYC - 1))
            begin
               r_d.core.react = DSW_RX_DONE;
               r_d.core.react_done = 1'b1;
            end
            else
            begin
               r_d.core.react_cnt = r_q.core.react_cnt + 17'h00001;
            end
         end
         DSW_RX_DONE:
         begin
            // held until the state machine leaves fault reaction
            r_d.core.react_done = drive_state == `DSW_ST_FAULT_REACT;
            if (drive_state != `DSW_ST_FAULT_REACT)
            begin
               r_d.core.react = DSW_RX_IDLE;
            end
         end
         default:
         begin
            r_d.core.react = DSW_RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         r_q.core.word <= `DSW_RESET_WORD;
         r_q.core.react <= DSW_RX_IDLE;
         r_q.core.react_cnt <= '0;
         r_q.core.react_done <= 1'b0;
         r_q.warn_s1 <= '0;
         r_q.warn_s2 <= '0;
         r_q.warn_s3 <= '0;
         r_q.warn_held <= '0;
         r_q.vend_s1 <= '0;
         r_q.vend_s2 <= '0;
         r_q.vend_s3 <= '0;
         r_q.vend_held <= '0;
         r_q.ilim_s1 <= '0;
         r_q.ilim_s2 <= '0;
         r_q.ilim_s3 <= '0;
         r_q.ilim_held <= '0;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // read-only: there is no write path at all
   assign drive_state_report = r_q.core.word;
   assign fault_react_done = r_q.core.react_done;

endmodule : dsw_drive_status_word_encoder

// [dsw_host.sv]
/*
 Host model: polls the status word once per clock.
 Assumes the word is read-only and sampled on clk_sys.
*/
`timescale 1ns/100ps
module dsw_host
(
   // clock
   input wire logic clk_sys,
   // status word in, last poll out
   input wire logic [15:0] drive_state_report,
   output logic [15:0] seen_word
);
   // polling only: the word has no write path to exercise
   always_ff @(posedge clk_sys)
      seen_word <= drive_state_report;
endmodule : dsw_host

// [dsw_pkg.sv]
/*
 Types for the drive status word encoder.
 Assumes dsw_consts.svh sits in the include path.
*/
package dsw_pkg;

   typedef enum logic [1:0]
   {
      DSW_RX_IDLE = 2'b00,
      DSW_RX_WAIT = 2'b01,
      DSW_RX_DONE = 2'b10
   } dsw_react_t;

   typedef struct packed
   {
      logic [15:0] word;
      dsw_react_t react;
      logic [16:0] react_cnt;
      logic react_done;
   } dsw_state_t;

endpackage : dsw_pkg

// [tb_drive_status_word_encoder.sv]
/*
 Testbench for the status word encoder with a polling host model.
 Assumes 50 MHz clk_sys and a shortened fault reaction dwell.
*/
`timescale 1ns/100ps
module tb_drive_status_word_encoder;
   localparam int RC = 10;
   localparam logic [6:0] ST [8] = '{7'h00, 7'h40, 7'h21, 7'h23,
      7'h27, 7'h07, 7'h0f, 7'h08};
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] drive_state = 3'h0;
   logic [2:0] op_mode = 3'h0;
   logic homing_active = 1'b0;
   logic motor_powered = 1'b0;
   logic service_owns_access = 1'b0;
   logic home_reached = 1'b0;
   logic at_target = 1'b0;
   logic homing_done = 1'b0;
   logic [7:0] warn_events = 8'h00;
   logic [7:0] vend_events = 8'h00;
   logic [7:0] ilim_events = 8'h00;
   logic [7:0] warn_select = 8'h00;
   logic [7:0] vend_select = 8'h00;
   logic [7:0] ilim_select = 8'h00;
   logic [15:0] drive_state_report;
   logic fault_react_done;
   logic [15:0] seen_word;
   int err_count = 0;
   int n_compared = 0;
   always #10 clk_sys = ~clk_sys;
   dsw_drive_status_word_encoder #(.EVT_W(8), .REACT_CYC(RC)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .drive_state(drive_state),
      .op_mode(op_mode), .homing_active(homing_active),
      .motor_powered(motor_powered),
      .service_owns_access(service_owns_access),
      .home_reached(home_reached), .at_target(at_target),
      .homing_done(homing_done), .warn_events(warn_events),
      .vend_events(vend_events), .ilim_events(ilim_events),
      .warn_select(warn_select), .vend_select(vend_select),
      .ilim_select(ilim_select), .drive_state_report(drive_state_report),
      .fault_react_done(fault_react_done));
   dsw_host host (.clk_sys(clk_sys),
      .drive_state_report(drive_state_report), .seen_word(seen_word));
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : step
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0, got}, {15'h0, exp});
   endtask : chk1
   // one edge for the encoder, one for the host poll
   task automatic rd(input logic [15:0] exp);
      step(2);
      chk16(seen_word, exp);
   endtask : rd
   function automatic logic [15:0] exp_word();
      logic t;
      t = (op_mode == 3'h6 || (op_mode == 3'h7 && homing_active))
         ? home_reached : at_target;
      return {3'h0, homing_done, |(ilim_events & ilim_select), t,
         !service_owns_access, |(vend_events & vend_select),
         |(warn_events & warn_select), ST[drive_state][6:5],
         motor_powered, ST[drive_state][3:0]};
   endfunction : exp_word
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   initial
   begin
      #100000;
      err_count++;
      test_done();
   end
   initial
   begin
      step(10);
      chk16(drive_state_report, 16'h0000);
      chk1(fault_react_done, 1'b0);
      resetn = 1'b1;
      step(2);
      $display("test reset done");
      for (int s = 0; s < 8; s++)
      begin
         drive_state = s[2:0];
         motor_powered = s[0];
         service_owns_access = s[1];
         at_target = s[2];
         homing_done = ~s[0];
         rd(exp_word());
      end
      $display("test states done");
      drive_state = 3'h4;
      for (int i = 0; i < 16; i++)
      begin
         op_mode = {i[3], i[3], i[2]};
         homing_active = i[1];
         home_reached = i[0];
         at_target = ~i[0];
         rd(exp_word());
      end
      $display("test modes done");
      warn_events = 8'h04;
      warn_select = 8'h04;
      vend_events = 8'h10;
      vend_select = 8'h01;
      ilim_events = 8'h80;
      ilim_select = 8'hff;
      step(5);
      rd(exp_word());
      warn_select = 8'hfb;
      vend_select = 8'h10;
      step(5);
      rd(exp_word());
      $display("test events done");
      drive_state = 3'h6;
      step(RC - 3);
      chk1(fault_react_done, 1'b0);
      // leave early and re-enter: the dwell must start over
      drive_state = 3'h5;
      step(1);
      drive_state = 3'h6;
      step(RC);
      chk1(fault_react_done, 1'b0);
      step(1);
      chk1(fault_react_done, 1'b1);
      step(4);
      chk1(fault_react_done, 1'b1);
      drive_state = 3'h7;
      step(2);
      chk1(fault_react_done, 1'b0);
      $display("test reaction done");
      resetn = 1'b0;
      step(2);
      chk16(drive_state_report, 16'h0000);
      chk1(fault_react_done, 1'b0);
      resetn = 1'b1;
      step(4);
      rd(exp_word());
      $display("test mid-run reset done");
      test_done();
   end
endmodule : tb_drive_status_word_encoder
